// [rtl/otf_delay_timer.sv]
`timescale 1ns/1ps
module otf_delay_timer #(
  parameter int MS_CYCLES = 200000,
  parameter int RISE_W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  otf_tmr_if.tmr tmr
);
  import otf_pkg::*;

  localparam int PRE_W = ($clog2(MS_CYCLES) > RISE_W) ? $clog2(MS_CYCLES) : RISE_W;
  localparam logic [PRE_W-1:0] PRE_RELOAD = PRE_W'(MS_CYCLES - 1);

  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic [PRE_W-1:0] pre_ff, nxt_pre;
  logic [3:0] ms_left_ff, nxt_ms_left;

  // A start restarts the count even while busy, so the sequencer owns the timing.
  always_comb begin
    nxt_busy = busy_ff;
    nxt_pre = pre_ff;
    nxt_ms_left = ms_left_ff;
    nxt_done = 1'b0;
    if (tmr.start) begin
      nxt_busy = 1'b1;
      if (tmr.use_rise) begin
        nxt_pre = (tmr.rise == '0) ? '0 : PRE_W'(tmr.rise - 1'b1);
        nxt_ms_left = 4'h0;
      end else begin
        nxt_pre = PRE_RELOAD;
        nxt_ms_left = (tmr.ms == 4'h0) ? 4'h0 : tmr.ms - 4'h1;
      end
    end else if (busy_ff) begin
      if (pre_ff != '0) begin
        nxt_pre = pre_ff - 1'b1;
      end else if (ms_left_ff != 4'h0) begin
        nxt_ms_left = ms_left_ff - 4'h1;
        nxt_pre = PRE_RELOAD;
      end else begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end
    end
  end

  // Plain registers for the timer state.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      pre_ff <= '0;
      ms_left_ff <= 4'h0;
    end else begin
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      pre_ff <= nxt_pre;
      ms_left_ff <= nxt_ms_left;
    end
  end

  assign tmr.done = done_ff;

endmodule

// [rtl/otf_fault_response.sv]
`timescale 1ns/1ps
module otf_fault_response #(
  parameter int MS_CYCLES = otf_pkg::OTF_MS_CYCLES,
  parameter int RISE_W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic [7:0] i_temp_deg,
  input wire logic i_die_shutdown,
  input wire logic i_output_request,
  input wire logic i_clear_faults,
  input wire logic [RISE_W-1:0] i_rise_cycles,
  output logic o_output_enable,
  output logic o_alert_line_n,
  output logic o_status_ot_fault,
  output logic o_ot_warning,
  output logic [2:0] o_retry_count,
  output logic o_latched
);
  import otf_pkg::*;

  // Refuse parameter values that the timer cannot count with.
  if (MS_CYCLES < 1 || RISE_W < 1 || RISE_W > 32) begin : g_bad_param
    $error("otf_fault_response: MS_CYCLES and RISE_W out of range");
  end

  otf_tmr_if #(.RISE_W(RISE_W)) tmr_if ();

  otf_delay_timer #(
    .MS_CYCLES(MS_CYCLES),
    .RISE_W(RISE_W)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .tmr(tmr_if.tmr)
  );

  // ---------------------------------------------------------------------
  // Register file.
  logic [7:0] action_ff, nxt_action;
  logic [7:0] fault_thr_ff, nxt_fault_thr;
  logic [7:0] warn_thr_ff, nxt_warn_thr;
  logic [7:0] rdata_ff, nxt_rdata;

  // Limits above the documented span are clamped, except the disable code.
  function automatic logic [7:0] clamp_thr(input logic [7:0] v);
    if (v == OTF_THR_OFF || v <= OTF_THR_MAX) begin
      clamp_thr = v;
    end else begin
      clamp_thr = OTF_THR_MAX;
    end
  endfunction

  // Writes land the cycle after the strobe; reads answer one cycle later.
  always_comb begin
    nxt_action = action_ff;
    nxt_fault_thr = fault_thr_ff;
    nxt_warn_thr = warn_thr_ff;
    nxt_rdata = rdata_ff;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        OTF_ADDR_ACTION: nxt_action = i_reg_wdata;
        OTF_ADDR_FAULT_THR: nxt_fault_thr = clamp_thr(i_reg_wdata);
        OTF_ADDR_WARN_THR: nxt_warn_thr = clamp_thr(i_reg_wdata);
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        OTF_ADDR_ACTION: nxt_rdata = action_ff;
        OTF_ADDR_FAULT_THR: nxt_rdata = fault_thr_ff;
        OTF_ADDR_WARN_THR: nxt_rdata = warn_thr_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Register storage.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      action_ff <= OTF_ACTION_RST;
      fault_thr_ff <= OTF_FAULT_THR_RST;
      warn_thr_ff <= OTF_WARN_THR_RST;
      rdata_ff <= 8'h00;
    end else begin
      action_ff <= nxt_action;
      fault_thr_ff <= nxt_fault_thr;
      warn_thr_ff <= nxt_warn_thr;
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------------
  // Field decode and temperature comparison.
  logic [1:0] resp;
  logic [2:0] retry;
  logic [2:0] dly;
  logic hot;
  logic warm;
  logic cool_ok;

  assign resp = action_ff[OTF_RESP_HI:OTF_RESP_LO];
  assign retry = action_ff[OTF_RETRY_HI:OTF_RETRY_LO];
  assign dly = action_ff[OTF_DLY_HI:OTF_DLY_LO];
  // The disable code turns off the limit only; the die sensor still trips.
  assign hot = (fault_thr_ff != OTF_THR_OFF) && (i_temp_deg >= fault_thr_ff);
  assign warm = (warn_thr_ff != OTF_THR_OFF) && (i_temp_deg >= warn_thr_ff);
  // With the warning disabled, cooling is judged against the fault limit instead.
  assign cool_ok = (warn_thr_ff == OTF_THR_OFF) ? !hot : !warm;

  // ---------------------------------------------------------------------
  // Fault response sequencer.
  otf_state_t state_ff, nxt_state;
  logic [2:0] tries_ff, nxt_tries;
  logic out_en_ff, nxt_out_en;
  logic status_ff, nxt_status;
  logic alert_n_ff, nxt_alert_n;
  logic warn_ff, nxt_warn;
  logic hot_q_ff, nxt_hot_q;
  logic tmr_start;
  logic tmr_use_rise;
  logic [3:0] tmr_ms;
  logic hot_rise;

  // Only a fresh crossing of the limit starts a response from the run state.
  assign hot_rise = hot && !hot_q_ff;

  // Milliseconds for a delay code; code zero maps to ten.
  function automatic logic [3:0] dly_ms(input logic [2:0] code);
    dly_ms = (code == 3'h0) ? OTF_DLY_CODE0_MS : {1'b0, code};
  endfunction

  always_comb begin
    nxt_state = state_ff;
    nxt_tries = tries_ff;
    nxt_out_en = out_en_ff;
    nxt_hot_q = hot;
    nxt_warn = warm;
    tmr_start = 1'b0;
    tmr_use_rise = 1'b0;
    tmr_ms = dly_ms(dly);
    // Sticky fault flag: a new fault in the clear cycle still sets it.
    nxt_status = hot || (status_ff && !i_clear_faults);
    nxt_alert_n = !nxt_status;
    unique case (state_ff)
      OTF_RUN: begin
        nxt_out_en = i_output_request;
        if (hot_rise && i_output_request) begin
          unique case (resp)
            OTF_RESP_IGNORE: nxt_state = OTF_RUN;
            OTF_RESP_DELAY: begin
              nxt_state = OTF_DELAY;
              tmr_start = 1'b1;
            end
            OTF_RESP_DISABLE: begin
              nxt_out_en = 1'b0;
              nxt_state = OTF_HICCUP;
              tmr_start = 1'b1;
            end
            OTF_RESP_COOL: begin
              nxt_out_en = 1'b0;
              nxt_state = OTF_COOL;
            end
          endcase
          if (resp != OTF_RESP_IGNORE && retry == OTF_RETRY_LATCH) begin
            nxt_out_en = 1'b0;
            nxt_state = OTF_LATCH;
            tmr_start = 1'b0;
          end
          if (resp == OTF_RESP_DELAY && retry == OTF_RETRY_LATCH) begin
            nxt_out_en = 1'b1;
            nxt_state = OTF_DELAY;
            tmr_start = 1'b1;
          end
        end
      end
      OTF_DELAY: begin
        // The output keeps running while the delay runs out.
        if (!hot) begin
          nxt_state = OTF_RUN;
        end else if (tmr_if.done) begin
          nxt_out_en = 1'b0;
          if (retry == OTF_RETRY_LATCH) begin
            nxt_state = OTF_LATCH;
          end else begin
            nxt_state = OTF_HICCUP;
            tmr_start = 1'b1;
          end
        end
      end
      OTF_COOL: begin
        nxt_out_en = 1'b0;
        if (cool_ok) begin
          nxt_state = OTF_HICCUP;
          tmr_start = 1'b1;
        end
      end
      OTF_HICCUP: begin
        // Off period of one attempt; code zero uses the rise time instead.
        nxt_out_en = 1'b0;
        if (tmr_if.done) begin
          nxt_state = OTF_RESTART;
          nxt_out_en = 1'b1;
          nxt_tries = (tries_ff == 3'h7) ? 3'h7 : tries_ff + 3'h1;
          tmr_start = 1'b1;
          tmr_use_rise = 1'b1;
        end
      end
      OTF_RESTART: begin
        // An attempt succeeds when the fault is gone once the output has risen.
        if (tmr_if.done) begin
          if (!hot) begin
            nxt_state = OTF_RUN;
            nxt_tries = 3'h0;
          end else if (retry == OTF_RETRY_FOREVER || tries_ff < retry) begin
            nxt_out_en = 1'b0;
            nxt_state = (resp == OTF_RESP_COOL) ? OTF_COOL : OTF_HICCUP;
            tmr_start = (resp != OTF_RESP_COOL);
          end else begin
            nxt_out_en = 1'b0;
            nxt_state = OTF_LOCK;
          end
        end
      end
      OTF_LATCH: begin
        nxt_out_en = 1'b0;
        if (i_clear_faults) begin
          nxt_state = OTF_RUN;
          nxt_tries = 3'h0;
        end
      end
      OTF_LOCK: begin
        // Only a reset leaves this state.
        nxt_out_en = 1'b0;
      end
      default: begin
        nxt_state = OTF_RUN;
        nxt_out_en = 1'b0;
      end
    endcase
    // Shared hiccup timing: delay code zero follows the rise time.
    if (tmr_start && nxt_state == OTF_HICCUP && dly == 3'h0) begin
      tmr_use_rise = 1'b1;
    end
    // Disabling the output ends any retry sequence, except the latch and the reset-only lock.
    if (!i_output_request && state_ff != OTF_LOCK && state_ff != OTF_LATCH) begin
      nxt_state = OTF_RUN;
      nxt_out_en = 1'b0;
      nxt_tries = 3'h0;
      tmr_start = 1'b0;
    end
    // The on-die shutdown overrides every mode, even a disabled fault limit.
    if (i_die_shutdown) begin
      nxt_out_en = 1'b0;
    end
  end

  assign tmr_if.start = tmr_start;
  assign tmr_if.use_rise = tmr_use_rise;
  assign tmr_if.ms = tmr_ms;
  assign tmr_if.rise = i_rise_cycles;

  // Sequencer state and output flops.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_ff <= OTF_RUN;
      tries_ff <= 3'h0;
      out_en_ff <= 1'b0;
      status_ff <= 1'b0;
      alert_n_ff <= 1'b1;
      warn_ff <= 1'b0;
      hot_q_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tries_ff <= nxt_tries;
      out_en_ff <= nxt_out_en;
      status_ff <= nxt_status;
      alert_n_ff <= nxt_alert_n;
      warn_ff <= nxt_warn;
      hot_q_ff <= nxt_hot_q;
    end
  end

  // Every output is a flop; the latched flag is the registered state decode.
  logic latched_ff, nxt_latched;

  assign nxt_latched = (nxt_state == OTF_LATCH) || (nxt_state == OTF_LOCK);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      latched_ff <= 1'b0;
    end else begin
      latched_ff <= nxt_latched;
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_output_enable = out_en_ff;
  assign o_alert_line_n = alert_n_ff;
  assign o_status_ot_fault = status_ff;
  assign o_ot_warning = warn_ff;
  assign o_retry_count = tries_ff;
  assign o_latched = latched_ff;

endmodule

// [rtl/otf_pkg.sv]
package otf_pkg;

  // Register offsets on the management port.
  localparam logic [7:0] OTF_ADDR_FAULT_THR = 8'h4f;
  localparam logic [7:0] OTF_ADDR_ACTION = 8'h50;
  localparam logic [7:0] OTF_ADDR_WARN_THR = 8'h51;

  // Field positions inside the fault action register.
  localparam int OTF_RESP_HI = 7;
  localparam int OTF_RESP_LO = 6;
  localparam int OTF_RETRY_HI = 5;
  localparam int OTF_RETRY_LO = 3;
  localparam int OTF_DLY_HI = 2;
  localparam int OTF_DLY_LO = 0;

  // Reset values of the registers.
  localparam logic [7:0] OTF_ACTION_RST = 8'h80;
  localparam logic [7:0] OTF_FAULT_THR_RST = 8'h7d;
  localparam logic [7:0] OTF_WARN_THR_RST = 8'h69;

  // Threshold range in degrees; the all-ones code switches a limit off.
  localparam logic [7:0] OTF_THR_MAX = 8'ha0;
  localparam logic [7:0] OTF_THR_OFF = 8'hff;

  // Response field codes.
  localparam logic [1:0] OTF_RESP_IGNORE = 2'h0;
  localparam logic [1:0] OTF_RESP_DELAY = 2'h1;
  localparam logic [1:0] OTF_RESP_DISABLE = 2'h2;
  localparam logic [1:0] OTF_RESP_COOL = 2'h3;

  // Retry field codes.
  localparam logic [2:0] OTF_RETRY_LATCH = 3'h0;
  localparam logic [2:0] OTF_RETRY_FOREVER = 3'h7;

  // Delay field code zero stands for a ten millisecond delay.
  localparam logic [3:0] OTF_DLY_CODE0_MS = 4'ha;

  // Timing: one millisecond expressed in clock cycles of the 5 ns clock.
  localparam int OTF_CLK_PERIOD_PS = 5000;
  localparam int OTF_MS_PS = 1000000000;
  localparam int OTF_MS_CYCLES = OTF_MS_PS / OTF_CLK_PERIOD_PS;

  // Fault response sequencer states.
  typedef enum logic [2:0] {
    OTF_RUN,
    OTF_DELAY,
    OTF_COOL,
    OTF_HICCUP,
    OTF_RESTART,
    OTF_LATCH,
    OTF_LOCK
  } otf_state_t;

endpackage

// [rtl/otf_tmr_if.sv]
`timescale 1ns/1ps
interface otf_tmr_if #(
  parameter int RISE_W = 16
);
  logic start;
  logic use_rise;
  logic [3:0] ms;
  logic [RISE_W-1:0] rise;
  logic done;

  modport ctl(output start, output use_rise, output ms, output rise, input done);
  modport tmr(input start, input use_rise, input ms, input rise, output done);
endinterface

// [sim/otf_fault_response_props.sv]
`timescale 1ns/1ps
module otf_fault_response_props #(
  parameter int MS_CYCLES = 20,
  parameter int RISE_W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] i_temp_deg,
  input wire logic i_output_request,
  input wire logic i_clear_faults,
  input wire logic i_die_shutdown,
  input logic o_output_enable,
  input logic o_alert_line_n,
  input logic o_status_ot_fault,
  input logic o_ot_warning,
  input logic [2:0] o_retry_count,
  input logic o_latched
);
  import otf_pkg::*;
  logic [7:0] lim_ff, warn_ff, act_ff, nxt_lim, nxt_warn, nxt_act, wd;
  logic hot, hot_ff;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Mirror the live configuration, with the same clamp the limits get.
  always_comb begin
    wd = (i_reg_wdata > OTF_THR_MAX && i_reg_wdata != OTF_THR_OFF) ? OTF_THR_MAX : i_reg_wdata;
    nxt_lim = (i_reg_wr && i_reg_addr == OTF_ADDR_FAULT_THR) ? wd : lim_ff;
    nxt_warn = (i_reg_wr && i_reg_addr == OTF_ADDR_WARN_THR) ? wd : warn_ff;
    nxt_act = (i_reg_wr && i_reg_addr == OTF_ADDR_ACTION) ? i_reg_wdata : act_ff;
    hot = i_temp_deg >= lim_ff && lim_ff != OTF_THR_OFF;
  end
  // Registered copies; the edge detector on hot finds the first crossing.
  always_ff @(posedge i_sys_clk) begin
    lim_ff <= i_rst ? OTF_FAULT_THR_RST : nxt_lim;
    warn_ff <= i_rst ? OTF_WARN_THR_RST : nxt_warn;
    act_ff <= i_rst ? OTF_ACTION_RST : nxt_act;
    hot_ff <= i_rst ? 1'b0 : hot;
  end
  a_alert_tracks: assert property (o_alert_line_n == !o_status_ot_fault)
    else $error("alert line disagrees with fault bit");
  a_fault_sets_status: assert property (hot |=> o_status_ot_fault)
    else $error("fault bit not set after crossing");
  // The die sensor may still stop the output in ignore mode, so it is kept out here.
  a_ignore_keeps_out: assert property (act_ff[7:6] == 2'h0 && o_output_enable
    && i_output_request && !i_die_shutdown |=> o_output_enable)
    else $error("ignore mode dropped output");
  a_disable_at_once: assert property (hot && !hot_ff && act_ff[7] && o_output_enable
    |=> !o_output_enable) else $error("output not disabled at once");
  a_delay_holds_on: assert property (hot && !hot_ff && act_ff[7:6] == 2'h1
    && act_ff[2:0] == 3'h1 && o_output_enable && i_output_request |=> o_output_enable [*8])
    else $error("output dropped before delay");
  a_latch_off_out: assert property (o_latched |-> !o_output_enable)
    else $error("output on while latched");
  a_die_forces_off: assert property (i_die_shutdown |=> !o_output_enable)
    else $error("output on during die shutdown");
  a_lock_holds: assert property (o_latched && !i_clear_faults |=> o_latched)
    else $error("latched state left without clear");
  a_count_bound: assert property (act_ff[5:3] != OTF_RETRY_FOREVER
    |-> o_retry_count <= act_ff[5:3]) else $error("too many restart attempts");
  a_clear_counter: assert property ($fell(o_status_ot_fault)
    |-> ##[0:1] o_retry_count == 3'h0) else $error("attempt count kept after clear");
  a_warn_late: assert property (!$past(i_rst) |-> o_ot_warning ==
    ($past(i_temp_deg) >= $past(warn_ff) && $past(warn_ff) != OTF_THR_OFF))
    else $error("warning flag wrong");
  c_latched: cover property (o_latched);
  c_count_max: cover property (o_retry_count == 3'h7);
  c_cleared: cover property ($fell(o_status_ot_fault));
endmodule
bind otf_fault_response otf_fault_response_props #(.MS_CYCLES(MS_CYCLES), .RISE_W(RISE_W))
  u_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_temp_deg(i_temp_deg), .i_output_request(i_output_request),
  .i_clear_faults(i_clear_faults), .i_die_shutdown(i_die_shutdown),
  .o_output_enable(o_output_enable),
  .o_alert_line_n(o_alert_line_n), .o_status_ot_fault(o_status_ot_fault),
  .o_ot_warning(o_ot_warning), .o_retry_count(o_retry_count), .o_latched(o_latched));

// [sim/otf_host_model.sv]
`timescale 1ns/1ps
module otf_host_model (
  input wire logic i_sys_clk,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata
);
  // Idle bus at time zero.
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end
  // Released lines show inverted values so stale data never looks valid.
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_reg_wr <= 1'b1;
    o_reg_addr <= a;
    o_reg_wdata <= d;
    @(posedge i_sys_clk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
  endtask
  // Read data is registered at the strobe edge and taken just after it.
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    o_reg_rd <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_sys_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    #1;
    d = i_reg_rdata;
  endtask
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import otf_pkg::*;
  localparam int MS = 20;
  localparam int RISE = 10;
  logic clk, rst, wr, rd, req, die, clr, en, alert_n, stat, warn, latched;
  logic [7:0] addr, wdata, rdata, temp;
  logic [2:0] cnt;
  int fails = 0;
  int samples_checked = 0;
  otf_host_model host (.i_sys_clk(clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
    .o_reg_wdata(wdata), .i_reg_rdata(rdata));
  otf_fault_response #(.MS_CYCLES(MS), .RISE_W(16)) uut (.i_sys_clk(clk), .i_rst(rst),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_temp_deg(temp), .i_die_shutdown(die), .i_output_request(req), .i_clear_faults(clr),
    .i_rise_cycles(16'(RISE)), .o_output_enable(en), .o_alert_line_n(alert_n),
    .o_status_ot_fault(stat), .o_ot_warning(warn), .o_retry_count(cnt), .o_latched(latched));
  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait on the output enable; a hang counts and ends the run.
  task automatic wait_en(input logic v, input int lim, output int n);
    n = 0;
    #1;
    while (en !== v) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        fails++;
        results();
      end
    end
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    temp <= 8'h1e;
    clr <= 1'b0;
    req <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic set_temp(input logic [7:0] t);
    @(posedge clk);
    temp <= t;
  endtask
  task automatic pulse_clear();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_regs();
    logic [7:0] d;
    do_reset();
    host.read(OTF_ADDR_ACTION, d);
    check(d, OTF_ACTION_RST);
    host.read(8'h52, d);
    check(d, 8'h00);
    host.write(OTF_ADDR_FAULT_THR, 8'hc8);
    host.read(OTF_ADDR_FAULT_THR, d);
    check(d, 8'ha0);
    host.write(OTF_ADDR_WARN_THR, 8'hff);
    host.read(OTF_ADDR_WARN_THR, d);
    check(d, 8'hff);
    host.write(OTF_ADDR_ACTION, 8'h5a);
    host.read(OTF_ADDR_ACTION, d);
    check(d, 8'h5a);
    $display("register test done");
  endtask
  task automatic t_ignore();
    int n;
    do_reset();
    host.write(OTF_ADDR_ACTION, 8'h00);
    wait_en(1'b1, 20, n);
    set_temp(8'h82);
    repeat (30) @(posedge clk);
    #1;
    check(8'(en), 8'h01);
    check(8'({stat, alert_n}), 8'h02);
    // The die sensor must stop the output even when the fault is ignored.
    @(posedge clk);
    die <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(8'(en), 8'h00);
    @(posedge clk);
    die <= 1'b0;
    set_temp(8'h1e);
    pulse_clear();
    check(8'({stat, alert_n}), 8'h01);
    $display("ignore test done");
  endtask
  task automatic t_delay();
    int n;
    do_reset();
    host.write(OTF_ADDR_ACTION, 8'h41);
    wait_en(1'b1, 20, n);
    set_temp(8'h82);
    wait_en(1'b0, 4 * MS, n);
    check(8'(n >= MS && n <= MS + 4), 8'h01);
    repeat (30) @(posedge clk);
    #1;
    check(8'({latched, en}), 8'h02);
    set_temp(8'h1e);
    pulse_clear();
    check(8'({latched, stat}), 8'h00);
    $display("delay test done");
  endtask
  task automatic t_retry();
    int n;
    do_reset();
    host.write(OTF_ADDR_ACTION, 8'h89);
    wait_en(1'b1, 20, n);
    set_temp(8'h82);
    wait_en(1'b0, 3, n);
    wait_en(1'b1, 4 * MS, n);
    check(8'(n >= MS - 2 && n <= MS + 4), 8'h01);
    check(8'(cnt), 8'h01);
    wait_en(1'b0, RISE + 4, n);
    repeat (2) @(posedge clk);
    pulse_clear();
    repeat (4 * MS) @(posedge clk);
    #1;
    check(8'({latched, en}), 8'h02);
    $display("retry test done");
  endtask
  task automatic t_cool();
    int n;
    do_reset();
    host.write(OTF_ADDR_ACTION, 8'hc9);
    wait_en(1'b1, 20, n);
    set_temp(8'h82);
    wait_en(1'b0, 3, n);
    set_temp(8'h6e);
    repeat (4 * MS) @(posedge clk);
    #1;
    check(8'(en), 8'h00);
    check(8'(warn), 8'h01);
    set_temp(8'h1e);
    wait_en(1'b1, 4 * MS, n);
    repeat (RISE + 6) @(posedge clk);
    #1;
    check(8'({cnt, en}), 8'h01);
    $display("cool test done");
  endtask
  task automatic t_forever();
    int n;
    do_reset();
    host.write(OTF_ADDR_ACTION, 8'hb9);
    wait_en(1'b1, 20, n);
    set_temp(8'h82);
    repeat (400) @(posedge clk);
    #1;
    check(8'({cnt, latched}), 8'h0e);
    wait_en(1'b1, 4 * MS, n);
    $display("forever test done");
  endtask
  // Delay code zero: ten milliseconds before acting, rise time for the hiccup off period.
  task automatic t_code0();
    int n;
    do_reset();
    host.write(OTF_ADDR_ACTION, 8'h40);
    wait_en(1'b1, 20, n);
    set_temp(8'h82);
    wait_en(1'b0, 12 * MS, n);
    check(8'(n >= 10 * MS && n <= 10 * MS + 4), 8'h01);
    do_reset();
    host.write(OTF_ADDR_ACTION, 8'h88);
    wait_en(1'b1, 20, n);
    set_temp(8'h82);
    wait_en(1'b0, 3, n);
    wait_en(1'b1, 4 * MS, n);
    check(8'(n >= RISE && n <= RISE + 3), 8'h01);
    $display("code zero test done");
  endtask
  // Inputs start idle; each scenario applies its own reset first.
  initial begin
    rst = 1'b1;
    req = 1'b0;
    die = 1'b0;
    clr = 1'b0;
    temp = 8'h1e;
    t_regs();
    t_ignore();
    t_delay();
    t_retry();
    t_cool();
    t_forever();
    t_code0();
    results();
  end
endmodule
